// ### include/bgd_pkg.sv
// shared constants, pin map and state types of the bridge gate drive block
package bgd_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int DEAD_GAP_NS = 300;
  localparam int DEAD_CYCLES_I = (DEAD_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_W = 5;
  localparam logic [GAP_W-1:0] DEAD_CYCLES = GAP_W'((DEAD_CYCLES_I < 1) ? 1 : DEAD_CYCLES_I);
  localparam int FAULT_CLEAR_US = 1000;
  localparam int CLEAR_W = 24;
  localparam logic [CLEAR_W-1:0] FAULT_CLEAR_CYCLES = CLEAR_W'(FAULT_CLEAR_US * CLK_MHZ);
  localparam logic [CLEAR_W-1:0] CLEAR_ONE = 24'h000001;

  // ****************************************
  // pin map of the synchronised inputs
  // ****************************************
  localparam int N_PHASE = 3;
  localparam int N_PIN = 11;
  localparam int PIN_HI = 0;
  localparam int PIN_LO = 3;
  localparam int PIN_AUX = 6;
  localparam int PIN_LB_TRIP = 7;
  localparam int PIN_GF_TRIP = 8;
  localparam int PIN_AUX_TRIP = 9;
  localparam int PIN_EN = 10;

  // ****************************************
  // state types and reset values
  // ****************************************
  typedef struct packed {
    logic hi_r;
    logic lo_r;
    logic last_hi_r;
    logic [GAP_W-1:0] gap_r;
  } bgd_chan_st_t;

  typedef struct packed {
    logic [N_PIN-1:0] s1_r;
    logic [N_PIN-1:0] s2_r;
    logic [N_PIN-1:0] s3_r;
    logic [N_PIN-1:0] filt_r;
    logic fault_r;
    logic [CLEAR_W-1:0] cnt_r;
    logic aux_r;
    logic dis_r;
  } bgd_top_st_t;

  localparam bgd_chan_st_t CHAN_RST = '{hi_r: 1'b0, lo_r: 1'b0, last_hi_r: 1'b0,
                                        gap_r: DEAD_CYCLES};
  localparam bgd_top_st_t TOP_RST = '0;

endpackage : bgd_pkg

// ### include/bgd_phase_if.sv
// carrier between the protection top and one phase channel
`timescale 1ns/1ps
interface bgd_phase_if;
  logic hi_cmd;
  logic lo_cmd;
  logic block;
  logic hi_gate;
  logic lo_gate;

  modport drv (
    output hi_cmd,
    output lo_cmd,
    output block,
    input hi_gate,
    input lo_gate
  );

  modport chan (
    input hi_cmd,
    input lo_cmd,
    input block,
    output hi_gate,
    output lo_gate
  );
endinterface : bgd_phase_if

// ### verilog/bgd_phase_chan.sv
// one half-bridge phase: shoot-through lockout and minimum dead gap
`timescale 1ns/1ps
module bgd_phase_chan (
  input wire logic clock,
  input wire logic nrst,
  bgd_phase_if.chan ph
);

  bgd_pkg::bgd_chan_st_t st_r;
  bgd_pkg::bgd_chan_st_t st_nxt;
  logic want_hi;
  logic want_lo;
  logic gap_ok_hi;
  logic gap_ok_lo;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    // both commands together give neither output
    want_hi = ph.hi_cmd & ~ph.lo_cmd & ~ph.block;
    want_lo = ph.lo_cmd & ~ph.hi_cmd & ~ph.block;
    // same-side retrigger needs no gap; partner needs the full gap
    gap_ok_hi = st_r.last_hi_r | (st_r.gap_r == bgd_pkg::DEAD_CYCLES);
    gap_ok_lo = ~st_r.last_hi_r | (st_r.gap_r == bgd_pkg::DEAD_CYCLES);
    st_nxt = st_r;
    st_nxt.hi_r = want_hi & ~st_r.lo_r & (st_r.hi_r | gap_ok_hi);
    st_nxt.lo_r = want_lo & ~st_r.hi_r & (st_r.lo_r | gap_ok_lo);
    if (st_nxt.hi_r | st_nxt.lo_r) begin
      st_nxt.gap_r = '0;
      st_nxt.last_hi_r = st_nxt.hi_r;
    end else if (st_r.gap_r != bgd_pkg::DEAD_CYCLES) begin
      // saturating count of cycles with both off
      st_nxt.gap_r = st_r.gap_r + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= bgd_pkg::CHAN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ph.hi_gate = st_r.hi_r;
  assign ph.lo_gate = st_r.lo_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_no_overlap: assert property (!(st_r.hi_r && st_r.lo_r))
    else $error("both gates of one phase on");
  chk_both_cmd_off: assert property (ph.hi_cmd && ph.lo_cmd |=> !st_r.hi_r && !st_r.lo_r)
    else $error("gate on while both commands high");
  chk_dead_gap_hi: assert property ($rose(st_r.hi_r) && !$past(st_r.last_hi_r) |->
      $past(st_r.gap_r) == bgd_pkg::DEAD_CYCLES)
    else $error("high gate on before dead gap ended");
  chk_dead_gap_lo: assert property ($rose(st_r.lo_r) && $past(st_r.last_hi_r) |->
      $past(st_r.gap_r) == bgd_pkg::DEAD_CYCLES)
    else $error("low gate on before dead gap ended");
  chk_long_gap_pass: assert property (want_hi && !st_r.lo_r &&
      st_r.gap_r == bgd_pkg::DEAD_CYCLES |=> st_r.hi_r)
    else $error("long gap delayed further");

  cov_hi_to_lo: cover property (st_r.hi_r ##1 !st_r.hi_r ##[1:40] st_r.lo_r);

endmodule : bgd_phase_chan

// ### verilog/bgd_gate_drive.sv
// three-phase gate drive protection top: input sync, trip latch, clear timer
`timescale 1ns/1ps
module bgd_gate_drive #(
  parameter logic [bgd_pkg::CLEAR_W-1:0] CLEAR_CYCLES = bgd_pkg::FAULT_CLEAR_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] high_side_command,
  input wire logic [2:0] low_side_command,
  input wire logic aux_command_in,
  input wire logic low_bus_trip,
  input wire logic ground_fault_trip,
  input wire logic aux_overcurrent_trip,
  input wire logic fault_enable_in,
  output logic fault_enable_out,
  output logic fault_enable_oe,
  output logic clear_timer_node_out,
  output logic clear_timer_node_oe,
  output logic [2:0] high_side_gate_out,
  output logic [2:0] low_side_gate_out,
  output logic aux_gate_out
);

  localparam logic [bgd_pkg::CLEAR_W-1:0] CLEAR_LAST = CLEAR_CYCLES - bgd_pkg::CLEAR_ONE;

  bgd_pkg::bgd_top_st_t st_r;
  bgd_pkg::bgd_top_st_t st_nxt;
  logic [bgd_pkg::N_PIN-1:0] pins;
  logic [bgd_pkg::N_PIN-1:0] differ;
  logic trip_any;
  logic enabled;
  logic block;

  // ****************************************
  // pin gathering and qualified levels
  // ****************************************
  assign pins = {fault_enable_in, aux_overcurrent_trip, ground_fault_trip, low_bus_trip,
                 aux_command_in, low_side_command, high_side_command};
  assign differ = st_r.s2_r ^ st_r.s3_r;

  // any of the three sources trips the bridge
  assign trip_any = st_r.filt_r[bgd_pkg::PIN_LB_TRIP] |
                    st_r.filt_r[bgd_pkg::PIN_GF_TRIP] |
                    st_r.filt_r[bgd_pkg::PIN_AUX_TRIP];
  // the line reads low while we pull it, so our own fault also disables
  assign enabled = st_r.filt_r[bgd_pkg::PIN_EN];
  assign block = trip_any | st_r.fault_r | ~enabled;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // three-stage sync; level moves once stages two and three agree
    st_nxt.s1_r = pins;
    st_nxt.s2_r = st_r.s1_r;
    st_nxt.s3_r = st_r.s2_r;
    st_nxt.filt_r = (st_r.s3_r & ~differ) | (st_r.filt_r & differ);

    // fault latch and clear counter
    if (trip_any) begin
      st_nxt.fault_r = 1'b1;
      st_nxt.cnt_r = '0;
    end else if (st_r.fault_r) begin
      if (st_r.cnt_r >= CLEAR_LAST) begin
        st_nxt.fault_r = 1'b0;
        st_nxt.cnt_r = '0;
      end else begin
        st_nxt.cnt_r = st_r.cnt_r + bgd_pkg::CLEAR_ONE;
      end
    end

    // timer node held discharged only while a trip is present
    st_nxt.dis_r = trip_any;
    st_nxt.aux_r = st_r.filt_r[bgd_pkg::PIN_AUX] & ~block;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= bgd_pkg::TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // open drain: only ever drive low
  assign fault_enable_out = 1'b0;
  assign fault_enable_oe = st_r.fault_r;
  assign clear_timer_node_out = 1'b0;
  assign clear_timer_node_oe = st_r.dis_r;
  assign aux_gate_out = st_r.aux_r;

  // ****************************************
  // phase channels
  // ****************************************
  generate
    for (genvar g = 0; g < bgd_pkg::N_PHASE; g++) begin : g_phase
      bgd_phase_if ph ();
      assign ph.hi_cmd = st_r.filt_r[bgd_pkg::PIN_HI + g];
      assign ph.lo_cmd = st_r.filt_r[bgd_pkg::PIN_LO + g];
      assign ph.block = block;
      bgd_phase_chan u_chan (
        .clock(clock),
        .nrst(nrst),
        .ph(ph.chan)
      );
      assign high_side_gate_out[g] = ph.hi_gate;
      assign low_side_gate_out[g] = ph.lo_gate;
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_aux_follow: assert property (st_r.filt_r[bgd_pkg::PIN_AUX] && !block
      |=> aux_gate_out)
    else $error("aux gate not following its command");
  chk_aux_blocked: assert property (block |=> !aux_gate_out)
    else $error("aux gate on while blocked");
  chk_fault_pull_low: assert property (fault_enable_oe |-> !fault_enable_out)
    else $error("fault pin driven high");
  chk_trip_shutdown: assert property (st_r.filt_r[bgd_pkg::PIN_LB_TRIP] |=>
      high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0 && !aux_gate_out &&
      fault_enable_oe && clear_timer_node_oe)
    else $error("low-bus trip did not shut down");
  chk_trip_sources: assert property (st_r.filt_r[bgd_pkg::PIN_GF_TRIP] ||
      st_r.filt_r[bgd_pkg::PIN_AUX_TRIP] |=> fault_enable_oe && clear_timer_node_oe &&
      high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("ground or aux trip not acting as low-bus trip");
  chk_fault_holds: assert property (st_r.fault_r && !trip_any && st_r.cnt_r < CLEAR_LAST
      |=> fault_enable_oe && !clear_timer_node_oe)
    else $error("fault released before clear interval");
  chk_release_count: assert property (st_r.fault_r && !trip_any &&
      st_r.cnt_r == CLEAR_LAST |=> !fault_enable_oe)
    else $error("fault not released at terminal count");
  chk_release_cause: assert property ($fell(fault_enable_oe) |->
      $past(st_r.cnt_r) == CLEAR_LAST && !$past(trip_any))
    else $error("fault released without terminal count");
  chk_gates_in_clear: assert property (st_r.fault_r |=>
      high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gate on during clear interval");
  chk_enable_low: assert property (!enabled |=> high_side_gate_out == 3'h0 &&
      low_side_gate_out == 3'h0 && !aux_gate_out)
    else $error("gate on while enable low");
  chk_restart: assert property (st_r.fault_r && trip_any |=> st_r.cnt_r == '0)
    else $error("trip did not restart clear counter");
  chk_count_step: assert property (st_r.fault_r && !trip_any && st_r.cnt_r < CLEAR_LAST
      |=> st_r.cnt_r == $past(st_r.cnt_r) + bgd_pkg::CLEAR_ONE)
    else $error("clear counter not advancing by one");
  chk_node_follow: assert property (trip_any |=> clear_timer_node_oe)
    else $error("timer node not discharged during trip");
  chk_node_release: assert property (!trip_any |=> !clear_timer_node_oe)
    else $error("timer node held after trip ended");
  chk_fault_rise: assert property ($rose(fault_enable_oe) |-> $past(trip_any))
    else $error("fault reported without a trip");
  chk_fault_idle: assert property (!trip_any && !st_r.fault_r |=> !fault_enable_oe)
    else $error("fault line pulled with no fault");
  chk_trip_aux: assert property (trip_any |=> !aux_gate_out)
    else $error("aux gate on during trip");
  chk_count_idle: assert property (!st_r.fault_r && !trip_any |=> st_r.cnt_r == '0)
    else $error("clear counter running with no fault");
  chk_gate_cause: assert property (high_side_gate_out != 3'h0 || low_side_gate_out != 3'h0
      |-> !$past(block))
    else $error("gate on after a blocked cycle");

  cov_trip_release: cover property (trip_any ##1 !trip_any ##[1:1000] !fault_enable_oe);
  cov_aux_on: cover property (!aux_gate_out ##1 aux_gate_out);
  cov_enable_block: cover property (enabled && high_side_gate_out != 3'h0 ##1 !enabled);
  cov_retrip: cover property (st_r.fault_r && !trip_any ##1 trip_any);

endmodule : bgd_gate_drive

// ### sim/bgd_ctrl_model.sv
// controller-side model of the shared fault/enable wire
`timescale 1ns/1ps
module bgd_ctrl_model (
  input wire logic fault_enable_oe,
  input wire logic fault_enable_out,
  input wire logic pull_low,
  output logic fault_wire
);
  // open drain: either party pulls low, else the pull-up wins
  assign fault_wire = ((fault_enable_oe && !fault_enable_out) || pull_low) ? 1'b0 : 1'b1;
endmodule : bgd_ctrl_model

// ### sim/bgd_gate_drive_tb.sv
// self-checking bench of the bridge gate drive block
`timescale 1ns/1ps
module bgd_gate_drive_tb;
  localparam logic [23:0] CLR = 24'h000014;
  localparam int DC = int'(bgd_pkg::DEAD_CYCLES);
  logic clock, nrst, aux_cmd, lb_trip, gf_trip, ax_trip, pull_low, fault_wire;
  logic [2:0] hi_cmd, lo_cmd, hs, ls;
  logic f_out, f_oe, n_out, n_oe, aux_out;
  logic [7:0] gate_v;
  int err_total, checks, cyc;
  assign gate_v = {1'b0, aux_out, ls, hs};
  bgd_gate_drive #(.CLEAR_CYCLES(CLR)) dut_u (
    .clock(clock), .nrst(nrst), .high_side_command(hi_cmd), .low_side_command(lo_cmd),
    .aux_command_in(aux_cmd), .low_bus_trip(lb_trip), .ground_fault_trip(gf_trip),
    .aux_overcurrent_trip(ax_trip), .fault_enable_in(fault_wire),
    .fault_enable_out(f_out), .fault_enable_oe(f_oe), .clear_timer_node_out(n_out),
    .clear_timer_node_oe(n_oe), .high_side_gate_out(hs), .low_side_gate_out(ls),
    .aux_gate_out(aux_out));
  bgd_ctrl_model ctrl_u (.fault_enable_oe(f_oe), .fault_enable_out(f_out),
    .pull_low(pull_low), .fault_wire(fault_wire));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // counts falling edges until the gate vector matches
  task automatic wait_gate(logic [7:0] exp, output int n);
    n = 0;
    while (gate_v !== exp && n < 60) begin
      tick(1);
      n++;
    end
  endtask : wait_gate
  task automatic t_follow;
    int n;
    for (int g = 0; g < 3; g++) begin
      hi_cmd = 3'(1 << g);
      wait_gate(8'(1 << g), n);
      chk("hi latency", 8'(n), 8'h05);
      hi_cmd = 3'h0;
      tick(20);
      lo_cmd = 3'(1 << g);
      wait_gate(8'(8 << g), n);
      chk("lo latency", 8'(n), 8'h05);
      lo_cmd = 3'h0;
      tick(20);
    end
    aux_cmd = 1'b1;
    wait_gate(8'h40, n);
    chk("aux latency", 8'(n), 8'h05);
    {aux_cmd, hi_cmd, lo_cmd} = {1'b0, 3'h1, 3'h2};
    wait_gate(8'h11, n);
    chk("mixed phases", 8'(n), 8'h05);
    {hi_cmd, lo_cmd} = 6'h00;
    tick(20);
    $display("test follow done");
  endtask : t_follow
  task automatic t_dead;
    int n;
    for (int g = 0; g < 3; g++) begin
      lo_cmd = 3'(1 << g);
      tick(8);
      {hi_cmd, lo_cmd} = {3'(1 << g), 3'h0};
      wait_gate(8'(1 << g), n);
      chk("gap lo to hi", 8'(n), 8'(5 + DC));
      {hi_cmd, lo_cmd} = {3'h0, 3'(1 << g)};
      wait_gate(8'(8 << g), n);
      chk("gap hi to lo", 8'(n), 8'(5 + DC));
      lo_cmd = 3'h0;
      tick(20);
    end
    $display("test dead gap done");
  endtask : t_dead
  task automatic t_shoot;
    int n;
    hi_cmd = 3'h1;
    wait_gate(8'h01, n);
    lo_cmd = 3'h1;
    tick(8);
    chk("both on early", gate_v, 8'h00);
    tick(10);
    chk("both on held", gate_v, 8'h00);
    {hi_cmd, lo_cmd} = 6'h00;
    tick(20);
    $display("test shoot-through done");
  endtask : t_shoot
  task automatic t_enable;
    int n;
    {hi_cmd, aux_cmd} = {3'h1, 1'b1};
    wait_gate(8'h41, n);
    pull_low = 1'b1;
    wait_gate(8'h00, n);
    chk("enable off", 8'(n), 8'h05);
    chk("no fault on enable", {7'h0, f_oe}, 8'h00);
    tick(10);
    chk("enable held", gate_v, 8'h00);
    pull_low = 1'b0;
    wait_gate(8'h41, n);
    chk("enable on", 8'(n), 8'h05);
    {hi_cmd, aux_cmd} = 4'h0;
    tick(20);
    $display("test enable done");
  endtask : t_enable
  task automatic t_trip(int src, bit again);
    int n;
    logic bad;
    {hi_cmd, aux_cmd} = {3'h1, 1'b1};
    wait_gate(8'h41, n);
    {ax_trip, gf_trip, lb_trip} = 3'(1 << src);
    wait_gate(8'h00, n);
    chk("trip shutdown", 8'(n), 8'h05);
    chk("trip report", {6'h0, f_oe, n_oe}, 8'h03);
    chk("wire low", {7'h0, fault_wire}, 8'h00);
    chk("pin levels", {6'h0, f_out, n_out}, 8'h00);
    tick(4);
    {ax_trip, gf_trip, lb_trip} = 3'h0;
    if (again) begin
      tick(10);
      lb_trip = 1'b1;
      tick(3);
      lb_trip = 1'b0;
    end
    tick(6);
    chk("node and fault", {6'h0, f_oe, n_oe}, 8'h02);
    n = 6;
    bad = 1'b0;
    while (f_oe === 1'b1 && n < 200) begin
      tick(1);
      n++;
      if (f_oe === 1'b1 && gate_v !== 8'h00) bad = 1'b1;
    end
    chk("gates held", {7'h0, bad}, 8'h00);
    chk("clear time", {7'h0, (n >= CLR + 4 && n <= CLR + 5)}, 8'h01);
    wait_gate(8'h41, n);
    chk("resume", {7'h0, (n <= 8)}, 8'h01);
    {hi_cmd, aux_cmd} = 4'h0;
    tick(20);
    $display("test trip %0d done", src);
  endtask : t_trip
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {nrst, aux_cmd, lb_trip, gf_trip, ax_trip, pull_low} = 6'h00;
    {hi_cmd, lo_cmd} = 6'h00;
    err_total = 0;
    checks = 0;
    cyc = 0;
    tick(5);
    nrst = 1'b1;
    tick(10);
    t_follow();
    t_dead();
    t_shoot();
    t_enable();
    for (int s = 0; s < 3; s++) t_trip(s, 1'b0);
    t_trip(0, 1'b1);
    print_verdict();
  end
endmodule : bgd_gate_drive_tb
